// ===== rtl/stmr_core.sv
// stmr_core: 10-bit standard timer with apb register access.
// assumes apb master on core_clk_in; high clock equals core clock,
// time base clock arrives as a one-cycle tick, pins asynchronous.
// Operation
// - ten-bit up counter advances on the selected timer clock.
// - P compares period value to bits 9..7; A compares all bits.
// - on rise clears counter; on fall holds counter value.
// - with counter on low, counting stops and timer is off.
// - pause freezes counter; clearing pause resumes from held value.
// - clock select picks sys/4, sys, high/16, high/64, tbc, pin.
// - period value gives value times 128 clocks; zero gives 1024.
// - clear select 1 clears on A; 0 clears on P or overflow.
// - clear select ignored in pwm, single pulse and capture modes.
// - mode field picks compare, capture, pwm/pulse, timer/counter.
// - compare mode A match: keep, drive low, high or toggle.
// - pwm mode: force inactive, force active, pwm, single pulse.
// - capture mode edge: rising, falling, both, or disabled.
// - output control sets initial pin level in compare mode.
// - output control is pwm active level, pulse start level.
// - polarity bit inverts the output pin except in timer mode.
// - swap bit exchanges period and duty sources in pwm mode.
// - on rise resets pin to initial level in output modes.
// - counter readable only; compare value readable and writable.
// - low bytes go through a buffer committed by high access.
// - A match raises A flag except in capture mode, where capture does; P match raises P flag unless cclr in compare or timer mode.
//
// The APB slave port and the register offsets were decided locally.
`include "stmr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module stmr_core
    import stmr_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        reset_n_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // timer pins and ticks
    input  wire logic        tbc_tick_in,
    input  wire logic        ext_clock_pin_in,
    input  wire logic        capture_input_pin_in,
    output logic             timer_output_pin_out,
    output logic             compare_a_flag_out,
    output logic             period_match_flag_out
);

    function automatic logic is_ofs(input logic [7:0] a,
                                    input logic [7:0] o);
        return a == o;
    endfunction

    // period value expanded to clocks, zero meaning full span
    function automatic logic [10:0] rp_span(input logic [2:0] rp);
        if (rp == 3'b000) begin
            return `STMR_FULL_SPAN;
        end
        return {1'b0, rp, 7'h00};
    endfunction

    logic        rs1_q;
    logic        rst_n;
    logic [7:0]  ctrl0_q, ctrl0_d;
    logic [7:0]  ctrl1_q, ctrl1_d;
    logic [9:0]  cnt_q, cnt_d;
    logic [9:0]  cmpa_q, cmpa_d;
    logic [7:0]  wbuf_q, wbuf_d;
    logic [7:0]  rbuf_q, rbuf_d;
    logic        flag_a_q, flag_a_d;
    logic        flag_p_q, flag_p_d;
    logic        on_prev_q;
    logic [5:0]  pre_q;
    logic [2:0]  ext_q;
    logic [2:0]  cap_q;
    logic        raw_q, raw_d;
    logic        pin_q, pin_d;
    logic [31:0] prdata_q, prdata_d;

    // reset release through two flops
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    logic          pause;
    logic          cnt_on;
    stmr_clk_sel_t clk_sel;
    logic [2:0]    period_value;
    stmr_mode_t    mode;
    logic [1:0]    pin_fn;
    logic          oc;
    logic          pol;
    logic          dpx;
    logic          cclr;

    assign pause        = ctrl0_q[`STMR_C0_PAUSE];
    assign clk_sel      = stmr_clk_sel_t'(
                          ctrl0_q[`STMR_C0_CLK_HI:`STMR_C0_CLK_LO]);
    assign cnt_on       = ctrl0_q[`STMR_C0_ON];
    assign period_value = ctrl0_q[`STMR_C0_RP_HI:0];
    assign mode         = stmr_mode_t'(
                          ctrl1_q[`STMR_C1_MODE_HI:`STMR_C1_MODE_LO]);
    assign pin_fn       = ctrl1_q[`STMR_C1_IO_HI:`STMR_C1_IO_LO];
    assign oc           = ctrl1_q[`STMR_C1_OC];
    assign pol          = ctrl1_q[`STMR_C1_POL];
    assign dpx          = ctrl1_q[`STMR_C1_DPX];
    assign cclr         = ctrl1_q[`STMR_C1_CCLR];

    // apb decode; slave answers with no wait state
    logic acc, wr, rd, setup, mapped;
    assign acc    = psel_in & penable_in;
    assign wr     = acc & pwrite_in;
    assign rd     = acc & ~pwrite_in;
    assign setup  = psel_in & ~penable_in;
    assign mapped = is_ofs(paddr_in, `STMR_OFS_CTRL0)
                  | is_ofs(paddr_in, `STMR_OFS_CTRL1)
                  | is_ofs(paddr_in, `STMR_OFS_CNT_LO)
                  | is_ofs(paddr_in, `STMR_OFS_CNT_HI)
                  | is_ofs(paddr_in, `STMR_OFS_CMPA_LO)
                  | is_ofs(paddr_in, `STMR_OFS_CMPA_HI)
                  | is_ofs(paddr_in, `STMR_OFS_STATUS);
    assign pready_out  = 1'b1;
    assign pslverr_out = acc & ~mapped;

    // timer clock source; high clock taken as the core clock
    logic src_tick, tick, on_rise;
    logic ext_rise, ext_fall, cap_rise, cap_fall;
    assign ext_rise = ext_q[1] & ~ext_q[2];
    assign ext_fall = ~ext_q[1] & ext_q[2];
    assign cap_rise = cap_q[1] & ~cap_q[2];
    assign cap_fall = ~cap_q[1] & cap_q[2];

    always_comb begin
        unique case (clk_sel)
            STMR_CK_SYS4: src_tick = (pre_q[1:0] == 2'h3);
            STMR_CK_SYS:  src_tick = 1'b1;
            STMR_CK_HI16: src_tick = (pre_q[3:0] == 4'hf);
            STMR_CK_HI64: src_tick = (pre_q == 6'h3f);
            STMR_CK_TBC:  src_tick = tbc_tick_in;
            STMR_CK_EXTR: src_tick = ext_rise;
            STMR_CK_EXTF: src_tick = ext_fall;
            STMR_CK_NONE: src_tick = 1'b0;
        endcase
    end

    assign tick    = cnt_on & ~pause & src_tick;
    assign on_rise = cnt_on & ~on_prev_q;

    // comparators look at the value the counter is about to take
    logic [9:0]  cnt_inc;
    logic        ovf, p_hit, a_hit, clr, cap_evt;
    logic [10:0] duty, period;
    logic        pwm_act;
    assign cnt_inc = cnt_q + 10'h001;
    assign ovf     = tick & (cnt_q == `STMR_CNT_MAX);
    assign p_hit   = (period_value == 3'b000) ? ovf
                   : tick & (cnt_inc[9:7] == period_value)
                          & (cnt_inc[6:0] == 7'h00);
    assign a_hit   = tick & (cmpa_q != 10'h000) & (cnt_inc == cmpa_q);

    always_comb begin
        unique case (mode)
            // period source fixed by swap bit
            STMR_MODE_PWM: clr = dpx ? a_hit : p_hit;
            STMR_MODE_CAP: clr = p_hit;
            default:       clr = cclr ? a_hit : p_hit;
        endcase
    end

    // duty at or above period holds output active
    assign period  = dpx ? ((cmpa_q == 10'h000) ? `STMR_FULL_SPAN
                                                : {1'b0, cmpa_q})
                         : rp_span(period_value);
    assign duty    = dpx ? rp_span(period_value) : {1'b0, cmpa_q};
    assign pwm_act = ({1'b0, cnt_q} < duty) | (duty >= period);

    // capture ignored while the timer is off
    always_comb begin
        unique case (pin_fn)
            2'b00:   cap_evt = cap_rise;
            2'b01:   cap_evt = cap_fall;
            2'b10:   cap_evt = cap_rise | cap_fall;
            default: cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt & cnt_on & (mode == STMR_MODE_CAP);
    end

    always_comb begin
        ctrl0_d  = ctrl0_q;
        ctrl1_d  = ctrl1_q;
        cnt_d    = cnt_q;
        cmpa_d   = cmpa_q;
        wbuf_d   = wbuf_q;
        rbuf_d   = rbuf_q;
        flag_a_d = flag_a_q;
        flag_p_d = flag_p_q;
        prdata_d = prdata_q;

        // counter
        if (on_rise) begin
            cnt_d = `STMR_RST_CNT;
        end else if (tick) begin
            cnt_d = clr ? `STMR_RST_CNT : cnt_inc;
        end

        // flags: software clear loses against a same-cycle set
        if (wr && is_ofs(paddr_in, `STMR_OFS_STATUS)) begin
            if (pwdata_in[`STMR_ST_FLAG_A]) begin
                flag_a_d = 1'b0;
            end
            if (pwdata_in[`STMR_ST_FLAG_P]) begin
                flag_p_d = 1'b0;
            end
        end
        if ((a_hit && mode != STMR_MODE_CAP) || cap_evt) begin
            flag_a_d = 1'b1;
        end
        if (p_hit && !(cclr && (mode == STMR_MODE_CMP
                               || mode == STMR_MODE_TMR))) begin
            flag_p_d = 1'b1;
        end

        if (cap_evt) begin
            cmpa_d = cnt_q;
        end

        // register writes; counter has no write path
        if (wr) begin
            if (is_ofs(paddr_in, `STMR_OFS_CTRL0)) begin
                ctrl0_d = pwdata_in[7:0];
            end
            if (is_ofs(paddr_in, `STMR_OFS_CTRL1)) begin
                ctrl1_d = pwdata_in[7:0];
            end
            if (is_ofs(paddr_in, `STMR_OFS_CMPA_LO)) begin
                wbuf_d = pwdata_in[7:0];
            end
            if (is_ofs(paddr_in, `STMR_OFS_CMPA_HI)) begin
                cmpa_d = {pwdata_in[1:0], wbuf_q};
            end
        end

        // high-byte reads latch the low byte for the next low read
        if (rd && is_ofs(paddr_in, `STMR_OFS_CNT_HI)) begin
            rbuf_d = cnt_q[7:0];
        end
        if (rd && is_ofs(paddr_in, `STMR_OFS_CMPA_HI)) begin
            rbuf_d = cmpa_q[7:0];
        end

        // read data prepared during the setup cycle
        if (setup) begin
            prdata_d = 32'h0000_0000;
            if (is_ofs(paddr_in, `STMR_OFS_CTRL0)) begin
                prdata_d[7:0] = ctrl0_q;
            end
            if (is_ofs(paddr_in, `STMR_OFS_CTRL1)) begin
                prdata_d[7:0] = ctrl1_q;
            end
            if (is_ofs(paddr_in, `STMR_OFS_CNT_LO)
                || is_ofs(paddr_in, `STMR_OFS_CMPA_LO)) begin
                prdata_d[7:0] = rbuf_q;
            end
            if (is_ofs(paddr_in, `STMR_OFS_CNT_HI)) begin
                prdata_d[1:0] = cnt_q[9:8];
            end
            if (is_ofs(paddr_in, `STMR_OFS_CMPA_HI)) begin
                prdata_d[1:0] = cmpa_q[9:8];
            end
            if (is_ofs(paddr_in, `STMR_OFS_STATUS)) begin
                prdata_d[`STMR_ST_FLAG_A] = flag_a_q;
                prdata_d[`STMR_ST_FLAG_P] = flag_p_q;
            end
        end
    end

    // output pin; registered, so it trails pwm levels by one cycle and compare or pulse events by two
    always_comb begin
        raw_d = raw_q;
        pin_d = raw_q;
        if (on_rise && mode != STMR_MODE_CAP
            && mode != STMR_MODE_TMR) begin
            raw_d = oc;
        end else if (mode == STMR_MODE_CMP && a_hit) begin
            unique case (pin_fn)
                2'b01:   raw_d = 1'b0;
                2'b10:   raw_d = 1'b1;
                2'b11:   raw_d = ~raw_q;
                default: raw_d = raw_q;
            endcase
        end else if (mode == STMR_MODE_PWM && pin_fn == 2'b11
                     && a_hit) begin
            raw_d = ~oc; // single pulse ends at compare A
        end
        if (mode == STMR_MODE_PWM) begin
            unique case (pin_fn)
                2'b00:   pin_d = ~oc;
                2'b01:   pin_d = oc;
                2'b10:   pin_d = (pwm_act & cnt_on) ? oc : ~oc;
                default: pin_d = raw_q;
            endcase
        end
        // timer mode drives the pin low
        pin_d = (mode == STMR_MODE_TMR) ? 1'b0 : (pin_d ^ pol);
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_q   <= `STMR_RST_CTRL;
            ctrl1_q   <= `STMR_RST_CTRL;
            cnt_q     <= `STMR_RST_CNT;
            cmpa_q    <= `STMR_RST_CNT;
            wbuf_q    <= 8'h00;
            rbuf_q    <= 8'h00;
            flag_a_q  <= 1'b0;
            flag_p_q  <= 1'b0;
            on_prev_q <= 1'b0;
            pre_q     <= 6'h00;
            ext_q     <= 3'h0;
            cap_q     <= 3'h0;
            raw_q     <= 1'b0;
            pin_q     <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            ctrl0_q   <= ctrl0_d;
            ctrl1_q   <= ctrl1_d;
            cnt_q     <= cnt_d;
            cmpa_q    <= cmpa_d;
            wbuf_q    <= wbuf_d;
            rbuf_q    <= rbuf_d;
            flag_a_q  <= flag_a_d;
            flag_p_q  <= flag_p_d;
            on_prev_q <= cnt_on;
            pre_q     <= pre_q + 6'h01;
            // bit 0 is a pure synchroniser stage, edges use 1 and 2
            ext_q     <= {ext_q[1:0], ext_clock_pin_in};
            cap_q     <= {cap_q[1:0], capture_input_pin_in};
            raw_q     <= raw_d;
            pin_q     <= pin_d;
            prdata_q  <= prdata_d;
        end
    end

    assign prdata_out            = prdata_q;
    assign timer_output_pin_out  = pin_q;
    assign compare_a_flag_out    = flag_a_q;
    assign period_match_flag_out = flag_p_q;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n);

    a_on_rise_clear: assert property (
        on_rise |=> cnt_q == 10'h000)
        else $error("counter not cleared on enable rise");
    a_off_hold: assert property (
        !cnt_on ##1 !cnt_on |-> $stable(cnt_q))
        else $error("counter moved while off");
    a_pause_hold: assert property (
        pause && !on_rise |=> cnt_q == $past(cnt_q))
        else $error("counter moved while paused");
    a_p_period: assert property (
        p_hit && !cclr && mode == STMR_MODE_CMP |=> cnt_q == 10'h000)
        else $error("period match did not clear counter");
    a_flag_a_set: assert property (
        a_hit && mode == STMR_MODE_CMP |=> flag_a_q)
        else $error("compare A flag not raised");
    a_cclr_no_p: assert property (
        cclr && mode == STMR_MODE_CMP && !flag_p_q |=> !flag_p_q)
        else $error("period flag raised with clear select set");
    a_init_level: assert property (
        on_rise && mode == STMR_MODE_CMP |=> ##1 pin_q == ($past(oc, 2)
                                                ^ $past(pol, 2)))
        else $error("pin not reset to initial level");
    a_rbuf_latch: assert property (
        rd && is_ofs(paddr_in, `STMR_OFS_CNT_HI)
        |=> rbuf_q == $past(cnt_q[7:0]))
        else $error("low byte not latched on high read");
    a_cmpa_commit: assert property (
        wr && is_ofs(paddr_in, `STMR_OFS_CMPA_HI) && !cap_evt
        |=> cmpa_q == {$past(pwdata_in[1:0]), $past(wbuf_q)})
        else $error("compare value not committed");

endmodule

`default_nettype wire

// ===== rtl/stmr_cfg.svh
// stmr_cfg.svh: offsets, field positions and reset values of the timer.
// assumes 32-bit apb words, byte addresses, registers in the low byte.
`ifndef STMR_CFG_SVH
`define STMR_CFG_SVH

`define STMR_OFS_CTRL0    8'h00
`define STMR_OFS_CTRL1    8'h04
`define STMR_OFS_CNT_LO   8'h08
`define STMR_OFS_CNT_HI   8'h0c
`define STMR_OFS_CMPA_LO  8'h10
`define STMR_OFS_CMPA_HI  8'h14
`define STMR_OFS_STATUS   8'h18

`define STMR_C0_PAUSE     7
`define STMR_C0_CLK_HI    6
`define STMR_C0_CLK_LO    4
`define STMR_C0_ON        3
`define STMR_C0_RP_HI     2
`define STMR_C1_MODE_HI   7
`define STMR_C1_MODE_LO   6
`define STMR_C1_IO_HI     5
`define STMR_C1_IO_LO     4
`define STMR_C1_OC        3
`define STMR_C1_POL       2
`define STMR_C1_DPX       1
`define STMR_C1_CCLR      0
`define STMR_ST_FLAG_A    0
`define STMR_ST_FLAG_P    1

`define STMR_RST_CTRL     8'h00
`define STMR_RST_CNT      10'h000
`define STMR_CNT_MAX      10'h3ff
`define STMR_FULL_SPAN    11'h400
`define STMR_RP_SHIFT     7

`endif

// ===== rtl/stmr_pkg.sv
// stmr_pkg: types shared by the standard timer core.
// assumes stmr_cfg.svh for all numeric constants.
package stmr_pkg;

    typedef enum logic [1:0] {
        STMR_MODE_CMP  = 2'b00,
        STMR_MODE_CAP  = 2'b01,
        STMR_MODE_PWM  = 2'b10,
        STMR_MODE_TMR  = 2'b11
    } stmr_mode_t;

    typedef enum logic [2:0] {
        STMR_CK_SYS4   = 3'b000,
        STMR_CK_SYS    = 3'b001,
        STMR_CK_HI16   = 3'b010,
        STMR_CK_HI64   = 3'b011,
        STMR_CK_TBC    = 3'b100,
        STMR_CK_NONE   = 3'b101,
        STMR_CK_EXTR   = 3'b110,
        STMR_CK_EXTF   = 3'b111
    } stmr_clk_sel_t;

endpackage

// ===== sim/stmr_core_test.sv
// stmr_core_test: self-checking apb testbench for the standard timer core.
// assumes stmr_core ports as declared, zero-wait apb, high clock = core.
`include "stmr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module stmr_core_test;
    logic        core_clk_in          = 1'b0;
    logic        reset_n_in           = 1'b0;
    logic        psel_in              = 1'b0;
    logic        penable_in           = 1'b0;
    logic        pwrite_in            = 1'b0;
    logic [7:0]  paddr_in             = 8'h00;
    logic [31:0] pwdata_in            = 32'h0000_0000;
    logic        tbc_tick_in          = 1'b0;
    logic        ext_clock_pin_in     = 1'b0;
    logic        capture_input_pin_in = 1'b0;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        timer_output_pin_out;
    logic        compare_a_flag_out;
    logic        period_match_flag_out;
    int          fails                = 0;
    int          total_checks         = 0;

    stmr_core i_stmr_core (
        .core_clk_in          (core_clk_in),
        .reset_n_in           (reset_n_in),
        .psel_in              (psel_in),
        .penable_in           (penable_in),
        .pwrite_in            (pwrite_in),
        .paddr_in             (paddr_in),
        .pwdata_in            (pwdata_in),
        .prdata_out           (prdata_out),
        .pready_out           (pready_out),
        .pslverr_out          (pslverr_out),
        .tbc_tick_in          (tbc_tick_in),
        .ext_clock_pin_in     (ext_clock_pin_in),
        .capture_input_pin_in (capture_input_pin_in),
        .timer_output_pin_out (timer_output_pin_out),
        .compare_a_flag_out   (compare_a_flag_out),
        .period_match_flag_out(period_match_flag_out)
    );

    always #4 core_clk_in = ~core_clk_in;

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask

    // entered and left just after a rising edge, bus idle in between
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= w;
        paddr_in   <= a;
        pwdata_in  <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        // no local limit: only the watchdog ends a wait
        do begin
            @(posedge core_clk_in);
        end while (pready_out !== 1'b1);
        r = prdata_out;
        e = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        @(posedge core_clk_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h000000, d}, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask

    // high byte first so the low read returns the latched byte
    task automatic rd10(input logic [7:0] hi, output logic [9:0] v);
        logic [31:0] h;
        logic [31:0] l;
        rd(hi, h);
        rd(hi - 8'h04, l);
        v = {h[1:0], l[7:0]};
    endtask

    task automatic wr10(input logic [9:0] v);
        wr(`STMR_OFS_CMPA_LO, v[7:0]);
        wr(`STMR_OFS_CMPA_HI, {6'h00, v[9:8]});
    endtask

    // one tick on tbc and one rising and one falling edge on the pin per pulse
    task automatic pulses(input int n);
        repeat (n) begin
            ext_clock_pin_in <= 1'b1;
            tbc_tick_in      <= 1'b1;
            @(posedge core_clk_in);
            tbc_tick_in      <= 1'b0;
            wait_cyc(3);
            ext_clock_pin_in <= 1'b0;
            wait_cyc(4);
        end
    endtask

    initial begin
        wait_cyc(40000);
        fails++;
        close_out();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        logic [9:0]  v1;
        logic [9:0]  v2;
        int          hi_cnt;
        logic [2:0]  sel_tab [4] = '{3'b100, 3'b110, 3'b111, 3'b101};
        int          cnt_tab [4] = '{5, 5, 5, 0};
        logic [7:0]  c1_tab  [7] = '{8'ha8, 8'hac, 8'haa, 8'ha8, 8'h88,
                                     8'h98, 8'hb8};
        logic [9:0]  a_tab   [7] = '{10'h020, 10'h020, 10'h100, 10'h0c8,
                                     10'h020, 10'h020, 10'h020};
        // single pulse: 32 active cycles, 19 of them before the window
        int          hi_tab  [7] = '{256, 768, 512, 1024, 0, 1024, 13};
        logic [7:0]  cap_tab [3] = '{8'h40, 8'h50, 8'h70};
        wait_cyc(3);
        reset_n_in <= 1'b1;
        wait_cyc(3);
        rd(`STMR_OFS_CTRL0, r);
        chk("control0 reset", 32'h0, r);
        rd(`STMR_OFS_CTRL1, r);
        chk("control1 reset", 32'h0, r);
        apb(1'b0, 8'h1c, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        wr10(10'h25a);
        rd10(`STMR_OFS_CMPA_HI, v1);
        chk("compare pair", 32'h25a, {22'h0, v1});
        wr(`STMR_OFS_CNT_LO, 8'h55);
        wr(`STMR_OFS_CNT_HI, 8'h03);
        rd10(`STMR_OFS_CNT_HI, v1);
        chk("counter read only", 32'h0, {22'h0, v1});
        // period 128 on system clock, clear on P
        wr(`STMR_OFS_CTRL0, 8'h19);
        wait_cyc(300);
        rd10(`STMR_OFS_CNT_HI, v1);
        chk("below period", 32'h1, {31'h0, v1 < 10'd128});
        rd(`STMR_OFS_STATUS, r);
        chk("p flag only", 32'h2, r & 32'h3);
        chk("flag pins", 32'h2,
            {30'h0, period_match_flag_out, compare_a_flag_out});
        chk("pin idle", 32'h0, {31'h0, timer_output_pin_out});
        // full span, then pause, off and restart
        wr(`STMR_OFS_CTRL0, 8'h10);
        wr(`STMR_OFS_CTRL0, 8'h18);
        wait_cyc(500);
        wr(`STMR_OFS_CTRL0, 8'h98);
        rd10(`STMR_OFS_CNT_HI, v1);
        wait_cyc(50);
        rd10(`STMR_OFS_CNT_HI, v2);
        chk("paused hold", {22'h0, v1}, {22'h0, v2});
        chk("beyond 128", 32'h1, {31'h0, v1 > 10'd400});
        wr(`STMR_OFS_CTRL0, 8'h18);
        wait_cyc(20);
        rd10(`STMR_OFS_CNT_HI, v2);
        chk("resumed", 32'h1, {31'h0, v2 > v1});
        wr(`STMR_OFS_CTRL0, 8'h10);
        rd10(`STMR_OFS_CNT_HI, v1);
        wait_cyc(50);
        rd10(`STMR_OFS_CNT_HI, v2);
        chk("off hold", {22'h0, v1}, {22'h0, v2});
        wr(`STMR_OFS_CTRL0, 8'h18);
        rd10(`STMR_OFS_CNT_HI, v2);
        chk("on clears", 32'h1, {31'h0, v2 < 10'd20});
        for (int i = 0; i < 4; i++) begin
            wr(`STMR_OFS_CTRL0, 8'h00);
            wr(`STMR_OFS_CTRL0, {1'b0, sel_tab[i], 4'h8});
            pulses(5);
            wait_cyc(6);
            rd10(`STMR_OFS_CNT_HI, v1);
            chk("source count", cnt_tab[i], {22'h0, v1});
        end
        // compare output: drive high on A match, clear on A
        wr(`STMR_OFS_CTRL0, 8'h00);
        wr10(10'd100);
        wr(`STMR_OFS_CTRL1, 8'h21);
        wr(`STMR_OFS_STATUS, 8'h03);
        chk("flags cleared", 32'h0,
            {30'h0, period_match_flag_out, compare_a_flag_out});
        wr(`STMR_OFS_CTRL0, 8'h18);
        wait_cyc(3);
        chk("initial low", 32'h0, {31'h0, timer_output_pin_out});
        wait_cyc(200);
        chk("match high", 32'h1, {31'h0, timer_output_pin_out});
        rd(`STMR_OFS_STATUS, r);
        chk("a flag only", 32'h1, r & 32'h3);
        chk("flag pins", 32'h1,
            {30'h0, period_match_flag_out, compare_a_flag_out});
        wr(`STMR_OFS_CTRL0, 8'h10);
        wr(`STMR_OFS_CTRL1, 8'h3d);
        wr(`STMR_OFS_CTRL0, 8'h18);
        wait_cyc(3);
        chk("restart level", 32'h0, {31'h0, timer_output_pin_out});
        wait_cyc(150);
        chk("toggled", 32'h1, {31'h0, timer_output_pin_out});
        // pwm: duty, polarity, swap, full duty and forced levels
        for (int i = 0; i < 7; i++) begin
            wr(`STMR_OFS_CTRL0, 8'h00);
            wr10(a_tab[i]);
            wr(`STMR_OFS_CTRL1, c1_tab[i]);
            wr(`STMR_OFS_CTRL0, 8'h19);
            wait_cyc(20);
            hi_cnt = 0;
            repeat (1024) begin
                @(posedge core_clk_in);
                if (timer_output_pin_out === 1'b1) hi_cnt++;
            end
            chk("pwm high cycles", hi_tab[i], hi_cnt);
        end
        // capture on rising edge, falling edge, then with capture disabled
        for (int i = 0; i < 3; i++) begin
            wr(`STMR_OFS_CTRL0, 8'h00);
            wr(`STMR_OFS_CTRL1, cap_tab[i]);
            wr(`STMR_OFS_STATUS, 8'h03);
            wr(`STMR_OFS_CTRL0, 8'h18);
            wait_cyc(100);
            capture_input_pin_in <= 1'b1;
            wait_cyc(10);
            capture_input_pin_in <= 1'b0;
            // falling edge needs the synchroniser delay before the read
            wait_cyc(5);
            rd(`STMR_OFS_STATUS, r);
            chk("capture flag", {31'h0, i != 2}, r & 32'h1);
        end
        wr(`STMR_OFS_CTRL0, 8'h10);
        rd10(`STMR_OFS_CMPA_HI, v1);
        // falling capture lands ten counts after the rising one would
        chk("captured value", 32'h1,
            {31'h0, v1 > 10'd107 && v1 < 10'd130});
        close_out();
    end
endmodule

`default_nettype wire
